// ### hdl/spi_cmd_pkg.sv
// Package for the serial register-access command engine.
// Assumes a 50 MHz core clock and an SPI mode 0 master (idle-low clock, MSB first).
package spi_cmd_pkg;
	// ==========================================================
	// Protocol characters
	localparam logic [7:0] HDR1_CHAR = 8'hC1;
	localparam logic [7:0] HDR2_CHAR = 8'hC2;
	localparam logic [7:0] ACK_CHAR = 8'h41;
	localparam logic [7:0] NAK_CHAR = 8'h4E;
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'h00;
	// ==========================================================
	// Header fields
	localparam int OP_HI = 7;
	localparam int OP_LO = 6;
	localparam int LEN_HI = 5;
	localparam int LEN_LO = 4;
	localparam int ADDR_HI = 3;
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// ==========================================================
	// Register access
	localparam int ADDR_W = 12;
	localparam int DATA_W = 64;
	localparam logic [3:0] LEN_ONE = 4'h1;
	// ==========================================================
	// Timing
	localparam int CLK_HZ = 50000000;
	localparam int TIMEOUT_MS = 320;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	typedef enum logic [2:0] {
		ST_HDR1,
		ST_HDR2,
		ST_WDATA,
		ST_WCRC,
		ST_BUSY,
		ST_RDATA,
		ST_RCRC
	} cmd_state_t;
endpackage

// ### hdl/reg_req_if.sv
// Interface carrying register requests from the command engine to the register port.
// Assumes one clock domain; request is a one-cycle pulse, done a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface reg_req_if;
	logic req;
	logic wr;
	logic [11:0] addr;
	logic [3:0] len;
	logic [63:0] wdata;
	logic done;
	logic [63:0] rdata;
	modport engine (output req, output wr, output addr, output len, output wdata, input done, input rdata);
	modport port (input req, input wr, input addr, input len, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ### hdl/reg_port.sv
// Register port: hands requests to the outside register space and waits for done.
// Assumes the register space answers each request with one done pulse.
`timescale 1ns/1ps
`default_nettype none
module reg_port (
	input wire logic core_clk,
	input wire logic nrst,
	reg_req_if.port rq,
	output logic ext_req_ff,
	output logic ext_wr_ff,
	output logic [11:0] ext_addr_ff,
	output logic [3:0] ext_len_ff,
	output logic [63:0] ext_wdata_ff,
	input wire logic ext_done,
	input wire logic [63:0] ext_rdata
);
	logic done_ff;
	logic [63:0] rdata_ff;
	assign rq.done = done_ff;
	assign rq.rdata = rdata_ff;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ext_req_ff <= 1'b0;
			ext_wr_ff <= 1'b0;
			ext_addr_ff <= 12'h000;
			ext_len_ff <= 4'h0;
			ext_wdata_ff <= 64'h0;
			done_ff <= 1'b0;
			rdata_ff <= 64'h0;
		end else begin
			ext_req_ff <= rq.req;
			done_ff <= ext_done;
			if (rq.req) begin
				ext_wr_ff <= rq.wr;
				ext_addr_ff <= rq.addr;
				ext_len_ff <= rq.len;
				ext_wdata_ff <= rq.wdata;
			end
			if (ext_done) begin
				rdata_ff <= ext_rdata;
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/spi_cmd_engine.sv
// Serial register-access command engine, SPI mode 0 slave with byte protocol,
// optional CRC, transaction timeout and register-bus configuration.
// Assumes sclk <= core_clk/8 and the master spaces bytes as the protocol demands.
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spi_cmd_engine
	import spi_cmd_pkg::*;
#(
	parameter logic [31:0] TIMEOUT_DEFAULT = 32'(spi_cmd_pkg::TIMEOUT_CYC)
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic ssel_n,
	input wire logic mosi,
	output logic miso_ff,
	output logic miso_oe_n_ff,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata_ff,
	output logic avs_waitrequest_ff,
	input wire logic calc_cycle_end,
	output logic ext_req_ff,
	output logic ext_wr_ff,
	output logic [11:0] ext_addr_ff,
	output logic [3:0] ext_len_ff,
	output logic [63:0] ext_wdata_ff,
	input wire logic ext_done,
	input wire logic [63:0] ext_rdata,
	output logic timeout_ff
);
	import spi_cmd_pkg::*;
	// ==========================================================
	// Register map of the control bus
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_TIMEOUT = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam int CFG_CRC_BIT = 0;
	localparam int CFG_DONE_BIT = 1;

	reg_req_if rq();
	reg_port u_port (
		.core_clk(core_clk),
		.nrst(nrst),
		.rq(rq),
		.ext_req_ff(ext_req_ff),
		.ext_wr_ff(ext_wr_ff),
		.ext_addr_ff(ext_addr_ff),
		.ext_len_ff(ext_len_ff),
		.ext_wdata_ff(ext_wdata_ff),
		.ext_done(ext_done),
		.ext_rdata(ext_rdata)
	);

	// ==========================================================
	// Synchronisers and edge detection
	logic [1:0] sclk_sync_ff, ssel_sync_ff, mosi_sync_ff;
	logic sclk_prev_ff;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_sync_ff <= 2'h0;
			ssel_sync_ff <= 2'h3;
			mosi_sync_ff <= 2'h0;
			sclk_prev_ff <= 1'b0;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[0], sclk};
			ssel_sync_ff <= {ssel_sync_ff[0], ssel_n};
			mosi_sync_ff <= {mosi_sync_ff[0], mosi};
			sclk_prev_ff <= sclk_sync_ff[1];
		end
	end
	wire selected = !ssel_sync_ff[1];
	wire sclk_rise = selected && sclk_sync_ff[1] && !sclk_prev_ff;
	wire sclk_fall = selected && !sclk_sync_ff[1] && sclk_prev_ff;

	// ==========================================================
	// Configuration, flag and bus slave
	logic crc_en_ff, calc_done_ff;
	logic [31:0] timeout_lim_ff;
	wire bus_wr = avs_write && !avs_waitrequest_ff;
	// Read data load as the request is taken, so they stand while waitrequest is low
	wire bus_rd = avs_read && avs_waitrequest_ff;
	wire [31:0] rd_mux = (avs_address == REG_CONFIG) ? {30'h0, calc_done_ff, crc_en_ff} :
		(avs_address == REG_TIMEOUT) ? timeout_lim_ff :
		(avs_address == REG_STATUS) ? {31'h0, timeout_ff} : 32'h0;
	wire clr_done = bus_wr && avs_address == REG_CONFIG && avs_writedata[CFG_DONE_BIT];
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			crc_en_ff <= 1'b0;
			calc_done_ff <= 1'b0;
			timeout_lim_ff <= TIMEOUT_DEFAULT;
			avs_waitrequest_ff <= 1'b1;
			avs_readdata_ff <= 32'h0;
		end else begin
			avs_waitrequest_ff <= !((avs_read || avs_write) && avs_waitrequest_ff);
			if (bus_rd) begin
				avs_readdata_ff <= rd_mux;
			end
			if (bus_wr && avs_address == REG_CONFIG) begin
				crc_en_ff <= avs_writedata[CFG_CRC_BIT];
			end
			if (bus_wr && avs_address == REG_TIMEOUT) begin
				timeout_lim_ff <= avs_writedata;
			end
			// Set wins over clear; only software clears it
			calc_done_ff <= calc_cycle_end || (calc_done_ff && !clr_done);
		end
	end
	// ==========================================================
	// Byte shifter
	logic [2:0] bit_cnt_ff;
	logic [7:0] rx_sh_ff, tx_sh_ff;
	wire byte_done = sclk_rise && bit_cnt_ff == BIT_LAST;
	wire [7:0] rx_byte = {rx_sh_ff[6:0], mosi_sync_ff[1]};

	// ==========================================================
	// Command state
	cmd_state_t state_ff;
	logic [1:0] op_ff;
	logic [3:0] len_ff, cnt_ff;
	logic [11:0] addr_ff;
	logic [63:0] data_ff;
	logic [7:0] crc_ff;
	logic ack_sent_ff, busy_ff, req_ff;
	logic [31:0] tmr_ff;
	logic tmr_run_ff;

	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < BYTE_BITS; i++) begin
			r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	wire [7:0] crc_nxt = crc_step(crc_ff, rx_byte);
	wire [3:0] hdr_len = LEN_ONE << rx_byte[LEN_HI:LEN_LO];
	wire hdr_ok = rx_byte[OP_HI:OP_LO] == OP_READ || rx_byte[OP_HI:OP_LO] == OP_WRITE;
	wire last_data = cnt_ff == len_ff - LEN_ONE;
	wire tmr_expired = tmr_run_ff && tmr_ff > timeout_lim_ff;
	// Index of the read byte that goes out next
	wire [2:0] rd_idx = state_ff == ST_RDATA ? cnt_ff[2:0] + 3'h1 : 3'h0;
	wire [5:0] rd_sel = {rd_idx, 3'h0};
	wire [7:0] rd_byte = rq.rdata[rd_sel +: 8];
	wire [7:0] ack_follow = op_ff == OP_WRITE ? HDR1_CHAR : rd_byte;

	// Byte loaded for the next transfer, chosen once the current byte ends
	logic [7:0] nxt_tx;
	always_comb begin
		nxt_tx = NAK_CHAR;
		case (state_ff)
			ST_HDR1: nxt_tx = hdr_ok ? HDR2_CHAR : HDR1_CHAR;
			ST_HDR2: nxt_tx = op_ff == OP_WRITE ? ACK_CHAR : NAK_CHAR;
			ST_WDATA: nxt_tx = last_data && !crc_en_ff ? NAK_CHAR : ACK_CHAR;
			ST_WCRC: nxt_tx = rx_byte == crc_ff ? NAK_CHAR : ACK_CHAR;
			ST_BUSY: nxt_tx = ack_sent_ff ? ack_follow : busy_ff ? NAK_CHAR : ACK_CHAR;
			ST_RDATA: nxt_tx = !last_data ? rd_byte : crc_en_ff ? crc_ff : HDR1_CHAR;
			ST_RCRC: nxt_tx = HDR1_CHAR;
			default: nxt_tx = HDR1_CHAR;
		endcase
	end

	assign rq.req = req_ff;
	assign rq.wr = op_ff == OP_WRITE;
	assign rq.addr = addr_ff;
	assign rq.len = len_ff;
	assign rq.wdata = data_ff;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bit_cnt_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			tx_sh_ff <= HDR1_CHAR;
			miso_ff <= 1'b0;
			miso_oe_n_ff <= 1'b1;
		end else begin
			miso_oe_n_ff <= !selected;
			if (sclk_rise) begin
				rx_sh_ff <= rx_byte;
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
			end
			// Mode 0: next bit goes out on the falling edge; the MSB waits in the byte gap
			if (sclk_fall && bit_cnt_ff != 3'h0) begin
				miso_ff <= tx_sh_ff[6];
				tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
			end else if (!selected || bit_cnt_ff == 3'h0 && !sclk_sync_ff[1]) begin
				miso_ff <= tx_sh_ff[7];
			end
			if (byte_done) begin
				tx_sh_ff <= nxt_tx;
			end
			// A dropped transaction restarts with a fresh header answer
			if (tmr_expired) begin
				bit_cnt_ff <= 3'h0;
				tx_sh_ff <= HDR1_CHAR;
			end
		end
	end
	// Command sequencer
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_HDR1;
			op_ff <= OP_READ;
			len_ff <= LEN_ONE;
			cnt_ff <= 4'h0;
			addr_ff <= 12'h000;
			data_ff <= 64'h0;
			crc_ff <= CRC_INIT;
			busy_ff <= 1'b0;
			req_ff <= 1'b0;
			ack_sent_ff <= 1'b0;
		end else begin
			req_ff <= 1'b0;
			if (rq.done) begin
				busy_ff <= 1'b0;
			end
			if (tmr_expired) begin
				state_ff <= ST_HDR1;
				busy_ff <= 1'b0;
				ack_sent_ff <= 1'b0;
			end else if (byte_done) begin
				case (state_ff)
					ST_HDR1: begin
						crc_ff <= crc_step(CRC_INIT, rx_byte);
						op_ff <= rx_byte[OP_HI:OP_LO];
						len_ff <= hdr_len;
						addr_ff[ADDR_W-1:8] <= rx_byte[ADDR_HI:0];
						state_ff <= hdr_ok ? ST_HDR2 : ST_HDR1;
					end
					ST_HDR2: begin
						crc_ff <= crc_nxt;
						addr_ff[7:0] <= rx_byte;
						cnt_ff <= 4'h0;
						data_ff <= 64'h0;
						if (op_ff == OP_WRITE) begin
							state_ff <= ST_WDATA;
						end else begin
							state_ff <= ST_BUSY;
							busy_ff <= 1'b1;
							req_ff <= 1'b1;
						end
					end
					ST_WDATA: begin
						crc_ff <= crc_nxt;
						data_ff[{cnt_ff[2:0], 3'h0} +: 8] <= rx_byte;
						cnt_ff <= cnt_ff + 4'h1;
						if (last_data) begin
							state_ff <= crc_en_ff ? ST_WCRC : ST_BUSY;
							busy_ff <= !crc_en_ff;
							req_ff <= !crc_en_ff;
						end
					end
					ST_WCRC: begin
						state_ff <= ST_BUSY;
						busy_ff <= rx_byte == crc_ff;
						req_ff <= rx_byte == crc_ff;
						// A rejected write has its final ACK already loaded
						ack_sent_ff <= rx_byte != crc_ff;
					end
					ST_BUSY: begin
						// Surplus bytes are sync bytes here, ignored while busy
						if (ack_sent_ff) begin
							ack_sent_ff <= 1'b0;
							cnt_ff <= 4'h0;
							state_ff <= op_ff == OP_WRITE ? ST_HDR1 : ST_RDATA;
							if (op_ff != OP_WRITE) begin
								crc_ff <= crc_step(crc_ff, rd_byte);
							end
						end else if (!busy_ff) begin
							ack_sent_ff <= 1'b1;
						end
					end
					ST_RDATA: begin
						// The CRC takes each data byte as it is loaded for sending
						cnt_ff <= cnt_ff + 4'h1;
						if (last_data) begin
							state_ff <= crc_en_ff ? ST_RCRC : ST_HDR1;
						end else begin
							crc_ff <= crc_step(crc_ff, rd_byte);
						end
					end
					ST_RCRC: state_ff <= ST_HDR1;
					default: state_ff <= ST_HDR1;
				endcase
			end
		end
	end

	// ==========================================================
	// Transaction timer, counted in core clocks
	wire txn_end = byte_done && (state_ff == ST_HDR1 ? !hdr_ok :
		(state_ff == ST_BUSY && ack_sent_ff && op_ff == OP_WRITE) ||
		(state_ff == ST_RDATA && last_data && !crc_en_ff) || state_ff == ST_RCRC);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tmr_ff <= 32'h0;
			tmr_run_ff <= 1'b0;
			timeout_ff <= 1'b0;
		end else begin
			if (tmr_expired || txn_end) begin
				tmr_run_ff <= 1'b0;
				tmr_ff <= 32'h0;
			end else if (byte_done && state_ff == ST_HDR1) begin
				tmr_run_ff <= 1'b1;
				tmr_ff <= 32'h0;
			end else if (tmr_run_ff) begin
				tmr_ff <= tmr_ff + 32'h1;
			end
			if (tmr_expired) begin
				timeout_ff <= 1'b1;
			end else if (byte_done && state_ff == ST_HDR1) begin
				timeout_ff <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/spi_cmd_chk.sv
// Port checker for the serial command engine.
// Bound to spi_cmd_engine; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module spi_cmd_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic ssel_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest_ff,
	input wire logic miso_ff,
	input wire logic miso_oe_n_ff,
	input wire logic ext_req_ff,
	input wire logic [3:0] ext_len_ff,
	input wire logic timeout_ff
);
	logic [7:0] idle_ff;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ====================================
	// Cycles since the serial clock moved
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			idle_ff <= 8'h00;
		else if ($changed(sclk))
			idle_ff <= 8'h00;
		else if (idle_ff != 8'hFF)
			idle_ff <= idle_ff + 8'h01;
	end
	// ====================================
	// Assertions
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest_ff |=> !avs_waitrequest_ff)
		else $error("waitrequest did not drop");
	bus_one_cycle_a: assert property ($fell(avs_waitrequest_ff) |=> avs_waitrequest_ff)
		else $error("waitrequest low too long");
	bus_no_spurious_a: assert property (!avs_read && !avs_write |=> avs_waitrequest_ff)
		else $error("answer without request");
	req_pulse_a: assert property (ext_req_ff |=> !ext_req_ff)
		else $error("register request longer than one cycle");
	req_len_a: assert property (ext_req_ff |-> ext_len_ff inside {4'h1, 4'h2, 4'h4, 4'h8})
		else $error("bad request length");
	req_clean_a: assert property (ext_req_ff |-> !timeout_ff)
		else $error("request from an abandoned transaction");
	tmo_idle_a: assert property ($rose(timeout_ff) |-> idle_ff > 8'h10)
		else $error("timeout while the link was active");
	oe_desel_a: assert property (ssel_n [*4] |-> miso_oe_n_ff)
		else $error("serial output driven while deselected");
	miso_fall_a: assert property ($changed(miso_ff) && !miso_oe_n_ff |-> !$past(sclk, 2))
		else $error("serial output moved while clock high");
	cover property (ext_req_ff && ext_len_ff == 4'h8);
	cover property ($rose(timeout_ff));
	cover property (!avs_waitrequest_ff);
endmodule
bind spi_cmd_engine spi_cmd_chk chk (.core_clk(core_clk), .nrst(nrst), .sclk(sclk), .ssel_n(ssel_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest_ff(avs_waitrequest_ff), .miso_ff(miso_ff),
	.miso_oe_n_ff(miso_oe_n_ff), .ext_req_ff(ext_req_ff), .ext_len_ff(ext_len_ff), .timeout_ff(timeout_ff));
`default_nettype wire

// ### sim/spi_host_model.sv
// Serial host model: mode 0 master, one byte per call.
// Assumes the caller keeps byte order and select as the protocol asks.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic core_clk,
	input wire logic miso,
	input wire logic miso_oe_n,
	output logic sclk,
	output logic ssel_n,
	output logic mosi
);
	logic last_bit;
	initial begin
		sclk = 1'b0;
		ssel_n = 1'b1;
		mosi = 1'b0;
		last_bit = 1'b0;
	end
	task automatic select(input logic en);
		@(posedge core_clk);
		ssel_n <= !en;
		repeat (8) @(posedge core_clk);
	endtask
	// 160 ns serial period, clock idles low between bytes
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi <= tx[i];
			repeat (4) @(posedge core_clk);
			sclk <= 1'b1;
			repeat (3) @(posedge core_clk);
			@(negedge core_clk);
			// A released line reads back as the inverse of its last level
			rx[i] = miso_oe_n ? ~last_bit : miso;
			last_bit = rx[i];
			@(posedge core_clk);
			sclk <= 1'b0;
		end
		repeat (420) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the serial command engine.
// Host model drives the serial side; the bench plays bus master and register space.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import spi_cmd_pkg::*;
	logic core_clk, nrst, sclk, ssel_n, mosi, miso_ff, miso_oe_n_ff, avs_read, avs_write;
	logic avs_waitrequest_ff, calc_cycle_end, ext_req_ff, ext_wr_ff, ext_done, timeout_ff, cap_wr, crc_on;
	logic [3:0] avs_address, ext_len_ff, cap_len;
	logic [7:0] b;
	logic [11:0] ext_addr_ff, cap_addr;
	logic [31:0] avs_writedata, avs_readdata_ff, seed, q;
	logic [63:0] ext_wdata_ff, ext_rdata, cap_wd;
	int bad_count, n_tests, n_req, dly;
	spi_cmd_engine #(.TIMEOUT_DEFAULT(32'h0000_07D0)) dut (.core_clk(core_clk), .nrst(nrst), .sclk(sclk),
		.ssel_n(ssel_n), .mosi(mosi), .miso_ff(miso_ff), .miso_oe_n_ff(miso_oe_n_ff), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
		.avs_waitrequest_ff(avs_waitrequest_ff), .calc_cycle_end(calc_cycle_end), .ext_req_ff(ext_req_ff),
		.ext_wr_ff(ext_wr_ff), .ext_addr_ff(ext_addr_ff), .ext_len_ff(ext_len_ff), .ext_wdata_ff(ext_wdata_ff),
		.ext_done(ext_done), .ext_rdata(ext_rdata), .timeout_ff(timeout_ff));
	spi_host_model host (.core_clk(core_clk), .miso(miso_ff), .miso_oe_n(miso_oe_n_ff), .sclk(sclk),
		.ssel_n(ssel_n), .mosi(mosi));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
		c = c ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
		return c;
	endfunction
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (k = 0; k < 100; k++) begin
			@(posedge core_clk);
			if (avs_waitrequest_ff === 1'b0)
				break;
		end
		r = avs_readdata_ff;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k == 100) begin
			bad_count++;
			print_verdict();
		end
	endtask
	// ====================================
	// Register space: answers each request after a random delay
	always @(posedge core_clk) begin
		ext_done <= 1'b0;
		if (ext_req_ff === 1'b1) begin
			{cap_wr, cap_addr, cap_len, cap_wd} <= {ext_wr_ff, ext_addr_ff, ext_len_ff, ext_wdata_ff};
			n_req <= n_req + 1;
			dly <= 20 + int'(rnd() % 40);
		end else if (dly > 0) begin
			dly <= dly - 1;
			ext_done <= (dly == 1);
		end
	end
	task automatic txn(input logic [1:0] op, input logic [1:0] lc, input logic [11:0] a, input logic badc);
		logic [7:0] rx, c;
		logic [63:0] v, m;
		int n, nak, r0;
		n = 1 << lc;
		v = {rnd(), rnd()};
		m = (n == 8) ? '1 : (64'h1 << (8 * n)) - 64'h1;
		ext_rdata <= v;
		r0 = n_req;
		c = crc(8'h00, {op, lc, a[11:8]});
		host.xfer({op, lc, a[11:8]}, rx);
		chk_byte(rx, HDR1_CHAR);
		c = crc(c, a[7:0]);
		host.xfer(a[7:0], rx);
		chk_byte(rx, HDR2_CHAR);
		if (op == OP_WRITE) begin
			for (int i = 0; i < n; i++) begin
				c = crc(c, v[8*i+:8]);
				host.xfer(v[8*i+:8], rx);
				chk_byte(rx, ACK_CHAR);
			end
			if (crc_on) begin
				host.xfer(c ^ {7'h00, badc}, rx);
				chk_byte(rx, ACK_CHAR);
			end
		end
		nak = 0;
		rx = NAK_CHAR;
		while (rx === NAK_CHAR && nak < 40) begin
			host.xfer(8'h00, rx);
			nak++;
		end
		if (rx === NAK_CHAR) begin
			bad_count++;
			print_verdict();
		end
		chk_byte(rx, ACK_CHAR);
		if (op == OP_WRITE) begin
			chk_word(64'(nak > 1), 64'(!badc));
			chk_word(64'(n_req - r0), 64'(!badc));
			if (!badc)
				chk_word(cap_wd & m, v & m);
		end else begin
			for (int i = 0; i < n; i++) begin
				host.xfer(8'h00, rx);
				chk_byte(rx, v[8*i+:8]);
				c = crc(c, v[8*i+:8]);
			end
			if (crc_on) begin
				host.xfer(8'h00, rx);
				chk_byte(rx, c);
			end
		end
		if (!badc)
			chk_word({cap_wr, cap_len, cap_addr}, {op == OP_WRITE, 4'(n), a});
	endtask
	// ====================================
	// Main sequence
	initial begin
		seed = 32'h0000_0055;
		{bad_count, n_tests, n_req, dly} = '0;
		{nrst, avs_read, avs_write, calc_cycle_end, ext_done, crc_on} = '0;
		{avs_address, avs_writedata, ext_rdata} = '0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		av(1'b0, 4'h0, 32'h0, q);
		chk_word(64'(q), 64'h0);
		av(1'b0, 4'h5, 32'h0, q);
		chk_word(64'(q), 64'h0);
		av(1'b1, 4'h1, 32'h0000_4E20, q);
		host.select(1'b1);
		txn(OP_WRITE, 2'h1, 12'(rnd()), 1'b0);
		txn(OP_READ, 2'h2, 12'(rnd()), 1'b0);
		for (int k = 1; k < 4; k += 2) begin
			host.xfer({2'(k), 6'h00}, b);
			chk_byte(b, HDR1_CHAR);
			txn(OP_READ, 2'h0, 12'(rnd()), 1'b0);
		end
		av(1'b1, 4'h0, 32'h1, q);
		crc_on = 1'b1;
		txn(OP_WRITE, 2'h0, 12'(rnd()), 1'b0);
		txn(OP_WRITE, 2'h0, 12'(rnd()), 1'b1);
		txn(OP_READ, 2'h3, 12'(rnd()), 1'b0);
		@(posedge core_clk);
		calc_cycle_end <= 1'b1;
		@(posedge core_clk);
		calc_cycle_end <= 1'b0;
		av(1'b0, 4'h0, 32'h0, q);
		chk_word(64'(q), 64'h3);
		av(1'b1, 4'h0, 32'h3, q);
		av(1'b0, 4'h0, 32'h0, q);
		chk_word(64'(q), 64'h1);
		av(1'b1, 4'h1, 32'h0000_05DC, q);
		host.xfer(8'h81, b);
		chk_byte(b, HDR1_CHAR);
		repeat (2500) @(posedge core_clk);
		av(1'b0, 4'h2, 32'h0, q);
		chk_word(64'(q), 64'h1);
		chk_word(64'(timeout_ff), 64'h1);
		av(1'b1, 4'h1, 32'h0000_4E20, q);
		txn(OP_WRITE, 2'h0, 12'(rnd()), 1'b0);
		av(1'b0, 4'h2, 32'h0, q);
		chk_word(64'(q), 64'h0);
		print_verdict();
	end
	initial begin
		repeat (90000) @(posedge core_clk);
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
